// >>> rtl/mos_pkg.sv
/*
  Constants for the multifunction output selector: source codes, condition
  vector layout, communication register map, control-cycle timing and the
  shared source decode function.
  Assumes a single 10 MHz system clock.
*/
package mos_pkg;

  // Source setting codes
  localparam logic [7:0] SRC_ZERO_RUN = 8'h21;
  localparam logic [7:0] SRC_ZERO_OR_STOP = 8'h22;
  localparam logic [7:0] SRC_ERROR_ONE = 8'h23;
  localparam logic [7:0] SRC_ERROR_TWO = 8'h24;
  localparam logic [7:0] SRC_ERROR_THREE = 8'h25;
  localparam logic [7:0] SRC_ERROR_FOUR = 8'h26;
  localparam logic [7:0] SRC_SPEED_REACHED = 8'h28;
  localparam logic [7:0] SRC_PULSE_SPEED_LOW = 8'h2B;
  localparam logic [7:0] SRC_VALVE_SWITCH = 8'h2D;
  localparam logic [7:0] SRC_MASTER_DEB = 8'h2E;
  localparam logic [7:0] SRC_COMM_MODBUS = 8'h33;
  localparam logic [7:0] SRC_COMM_CARD = 8'h34;
  localparam logic [7:0] SRC_FIRE_MODE = 8'h35;

  // Condition vector layout
  localparam int COND_W = 11;
  localparam int COND_RUN = 0;
  localparam int COND_FREQ_ZERO = 1;
  localparam int COND_SPEED_REACHED = 2;
  localparam int COND_ERR_BASE = 3;
  localparam int COND_PULSE_LOW = 7;
  localparam int COND_VALVE = 8;
  localparam int COND_DEB = 9;
  localparam int COND_FIRE = 10;

  // Register map
  localparam logic [15:0] ADDR_COMM_OUTPUT_VALUE = 16'h2640;
  localparam logic [15:0] ADDR_OUTPUT_STATUS = 16'h2641;
  localparam logic [15:0] COMM_OUTPUT_VALUE_RESET = 16'h0000;
  localparam logic [15:0] COMM_OUTPUT_VALUE_MASK = 16'h0019;
  localparam int BIT_RELAY = 0;
  localparam int BIT_OUT_ONE = 3;
  localparam int BIT_OUT_TWO = 4;

  // Control cycle timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int CTRL_CYCLE_NS = 1000;
  localparam int CTRL_CYCLE_CLKS = (CTRL_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_W = 4;

  // Terminal kinds
  typedef enum logic [1:0] {TERM_RELAY, TERM_OUT_ONE, TERM_OUT_TWO} mos_term_type;

  function automatic logic mos_pick(
    input logic [7:0] code,
    input logic [COND_W-1:0] cond,
    input logic commBit,
    input logic isDigital
  );
    logic result;
    result = 1'b0;
    case (code)
      SRC_ZERO_RUN: result = cond[COND_RUN] & cond[COND_FREQ_ZERO];
      SRC_ZERO_OR_STOP: result = cond[COND_FREQ_ZERO] | ~cond[COND_RUN];
      SRC_ERROR_ONE: result = cond[COND_ERR_BASE];
      SRC_ERROR_TWO: result = cond[COND_ERR_BASE+1];
      SRC_ERROR_THREE: result = cond[COND_ERR_BASE+2];
      SRC_ERROR_FOUR: result = cond[COND_ERR_BASE+3];
      SRC_SPEED_REACHED: result = cond[COND_SPEED_REACHED] | ~cond[COND_RUN];
      SRC_PULSE_SPEED_LOW: result = cond[COND_PULSE_LOW];
      SRC_VALVE_SWITCH: result = cond[COND_VALVE];
      SRC_MASTER_DEB: result = isDigital & cond[COND_DEB];
      SRC_COMM_MODBUS: result = commBit;
      SRC_COMM_CARD: result = commBit;
      SRC_FIRE_MODE: result = cond[COND_FIRE];
      default: result = 1'b0;
    endcase
    return result;
  endfunction

endpackage

// >>> rtl/mos_sync.sv
/*
  Two-flop synchroniser for a group of pin levels.
  Assumes each bit is an independent, slowly changing level.
*/
`timescale 1ns/1ps
`default_nettype none
module mos_sync #(
  parameter int WIDTH = 2
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stageOne;

  // First stage feeds only the second
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      stageOne <= '0;
      syncOut <= '0;
    end else begin
      stageOne <= asyncIn;
      syncOut <= stageOne;
    end
  end
endmodule // mos_sync
`default_nettype wire

// >>> rtl/mos_tick.sv
/*
  Control-cycle tick generator: one-cycle pulse every CTRL_CYCLE_CLKS clocks.
  Assumes the system clock of the package.
*/
`timescale 1ns/1ps
`default_nettype none
module mos_tick
  import mos_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  output logic tick
);
  localparam logic [TICK_W-1:0] LAST = TICK_W'(CTRL_CYCLE_CLKS - 1);
  logic [TICK_W-1:0] count;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= '0;
    end else if (count == LAST) begin
      count <= '0;
    end else begin
      count <= count + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tick <= 1'b0;
    end else begin
      tick <= (count == LAST);
    end
  end
endmodule // mos_tick
`default_nettype wire

// >>> rtl/mos_selector.sv
/*
  Multifunction output selector: drives the relay and the two digital output
  terminals from the condition chosen by each terminal's source setting, and
  holds the communication output-value register.
  Assumes the drive status inputs come from logic on sys_clk, the enable and
  fire-mode digital inputs come straight from pins, and the source settings
  come from the parameter store on sys_clk.
*/
// How it works
// - Code 33 drives the terminal while the drive runs at zero actual frequency.
// - Code 34 drives the terminal while actual frequency is zero or the drive is stopped.
// - Codes 35 to 38 follow error selection flags one to four in that order.
// - Code 40 drives the terminal when the commanded frequency is reached or the drive is stopped.
// - Code 43 drives the terminal when the pulse input is in use and measured speed is below the threshold.
// - Code 45 switches the output contactor valve with the drive state while the enable input is active.
// - Code 46 lets a master signal its deceleration energy backup on either digital output.
// - Codes 51 and 52 hand the terminal to the communication register.
// - Under communication control the relay follows bit 0, output one bit 3, output two bit 4.
// - Code 53 drives the terminal while the fire mode input is active.
`timescale 1ns/1ps
`default_nettype none
module mos_selector
  import mos_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [7:0] relaySourceSelect,
  input wire logic [7:0] outOneSourceSelect,
  input wire logic [7:0] outTwoSourceSelect,
  input wire logic driveRunning,
  input wire logic actualFreqZero,
  input wire logic speedReached,
  input wire logic [3:0] errorSelectFlag,
  input wire logic pulseInputTerminalMode,
  input wire logic [15:0] motorSpeed,
  input wire logic [15:0] speedThreshold,
  input wire logic decelEnergyBackup,
  input wire logic driveEnablePin,
  input wire logic fireModePin,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [15:0] regAddr,
  input wire logic [15:0] regWrData,
  output logic [15:0] regRdData,
  output logic regRdValid,
  output logic relayOutput,
  output logic digitalOutputOne,
  output logic digitalOutputTwo
);
  logic [1:0] pinSync;
  logic tick;
  logic [15:0] commOutputValue;
  logic [COND_W-1:0] condNow;
  logic [2:0] next_terminal;
  logic [2:0] terminalState;
  logic [7:0] srcSel [3];
  logic [2:0] commBits;

  mos_sync #(.WIDTH(2)) pinSyncInst (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .asyncIn({fireModePin, driveEnablePin}),
    .syncOut(pinSync)
  );

  mos_tick tickInst (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .tick(tick)
  );

  // Condition vector seen by every terminal
  always_comb begin
    condNow = '0;
    condNow[COND_RUN] = driveRunning;
    condNow[COND_FREQ_ZERO] = actualFreqZero;
    condNow[COND_SPEED_REACHED] = speedReached;
    condNow[COND_ERR_BASE +: 4] = errorSelectFlag;
    condNow[COND_PULSE_LOW] = pulseInputTerminalMode & (motorSpeed < speedThreshold);
    condNow[COND_VALVE] = pinSync[0] & driveRunning;
    condNow[COND_DEB] = decelEnergyBackup;
    condNow[COND_FIRE] = pinSync[1];
  end

  assign srcSel[0] = relaySourceSelect;
  assign srcSel[1] = outOneSourceSelect;
  assign srcSel[2] = outTwoSourceSelect;
  assign commBits = {commOutputValue[BIT_OUT_TWO], commOutputValue[BIT_OUT_ONE],
    commOutputValue[BIT_RELAY]};

  // Relay cannot carry the backup signal, only the digital outputs can
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_term
      assign next_terminal[gi] = mos_pick(srcSel[gi], condNow, commBits[gi], gi != 0);
    end
  endgenerate

  // Hold between ticks so a terminal never chatters mid-cycle
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      terminalState <= '0;
    end else if (tick) begin
      terminalState <= next_terminal;
    end
  end

  assign relayOutput = terminalState[0];
  assign digitalOutputOne = terminalState[1];
  assign digitalOutputTwo = terminalState[2];

  // Communication register; unused bits stay zero
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      commOutputValue <= COMM_OUTPUT_VALUE_RESET;
    end else if (regWrEn && regAddr == ADDR_COMM_OUTPUT_VALUE) begin
      commOutputValue <= regWrData & COMM_OUTPUT_VALUE_MASK;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdData <= '0;
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= regRdEn;
      if (!regRdEn) begin
        regRdData <= '0;
      end else if (regAddr == ADDR_COMM_OUTPUT_VALUE) begin
        regRdData <= commOutputValue;
      end else if (regAddr == ADDR_OUTPUT_STATUS) begin
        regRdData <= {13'h0000, terminalState};
      end else begin
        regRdData <= '0;
      end
    end
  end

  // Checks
  property p_src(logic [7:0] sel, int idx, logic [7:0] code, logic expect_v);
    @(posedge sys_clk) disable iff (!arst_n)
      (tick && sel == code) |=> terminalState[idx] == $past(expect_v);
  endproperty

  AST_ZERO_RUN: assert property (
    p_src(relaySourceSelect, 0, SRC_ZERO_RUN, driveRunning & actualFreqZero))
    else $error("Zero speed in run output wrong");

  AST_ZERO_RUN_TWO: assert property (
    p_src(outTwoSourceSelect, 2, SRC_ZERO_RUN, driveRunning & actualFreqZero))
    else $error("Zero speed in run wrong on output two");

  AST_ZERO_STOP: assert property (
    p_src(outOneSourceSelect, 1, SRC_ZERO_OR_STOP, actualFreqZero | ~driveRunning))
    else $error("Zero speed or stop output wrong");

  AST_ERR_ONE: assert property (
    p_src(relaySourceSelect, 0, SRC_ERROR_ONE, errorSelectFlag[0]))
    else $error("Error flag one not followed");

  AST_ERR_TWO: assert property (
    p_src(outOneSourceSelect, 1, SRC_ERROR_TWO, errorSelectFlag[1]))
    else $error("Error flag two not followed");

  AST_ERR_FOUR: assert property (
    p_src(outTwoSourceSelect, 2, SRC_ERROR_FOUR, errorSelectFlag[3]))
    else $error("Error flag four not followed");

  AST_SPEED_RUN: assert property (
    p_src(outTwoSourceSelect, 2, SRC_SPEED_REACHED, speedReached | ~driveRunning))
    else $error("Speed reached output wrong");

  AST_PULSE_LOW: assert property (
    p_src(outOneSourceSelect, 1, SRC_PULSE_SPEED_LOW, pulseInputTerminalMode & (motorSpeed < speedThreshold)))
    else $error("Pulse speed detection wrong");

  AST_PULSE_RELAY: assert property (
    p_src(relaySourceSelect, 0, SRC_PULSE_SPEED_LOW, pulseInputTerminalMode & (motorSpeed < speedThreshold)))
    else $error("Pulse speed detection wrong on relay");

  AST_DEB_OUT: assert property (
    p_src(outTwoSourceSelect, 2, SRC_MASTER_DEB, decelEnergyBackup))
    else $error("Backup signal not sent on output two");

  AST_DEB_ONE: assert property (
    p_src(outOneSourceSelect, 1, SRC_MASTER_DEB, decelEnergyBackup))
    else $error("Backup signal not sent on output one");

  AST_ERR_THREE: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
      (tick && outTwoSourceSelect == SRC_ERROR_THREE) |=> digitalOutputTwo == $past(errorSelectFlag[2]))
    else $error("Error flag three not followed");

  AST_SPEED_STOP: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
      (tick && relaySourceSelect == SRC_SPEED_REACHED && !driveRunning) |=> relayOutput)
    else $error("Speed reached output low while stopped");

  // Pins reach the terminals two clocks late through the synchroniser
  AST_VALVE: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
      (tick && outOneSourceSelect == SRC_VALVE_SWITCH && $past(driveEnablePin, 3)
        && $past(driveEnablePin, 2) && driveRunning) |=> digitalOutputOne)
    else $error("Valve not switched on with enable and run");

  AST_VALVE_OFF: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
      (tick && outTwoSourceSelect == SRC_VALVE_SWITCH && !driveRunning) |=> !digitalOutputTwo)
    else $error("Valve on while drive stopped");

  AST_DEB_RELAY: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
      (tick && relaySourceSelect == SRC_MASTER_DEB) |=> !relayOutput)
    else $error("Relay carried backup signal");

  AST_COMM_BITS: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
      (tick && (outOneSourceSelect == SRC_COMM_MODBUS || outOneSourceSelect == SRC_COMM_CARD))
        |=> digitalOutputOne == $past(commOutputValue[3]))
    else $error("Output one not following register bit 3");

  AST_COMM_RELAY: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
      (tick && (relaySourceSelect == SRC_COMM_MODBUS || relaySourceSelect == SRC_COMM_CARD))
        |=> relayOutput == $past(commOutputValue[0]))
    else $error("Relay not following register bit 0");

  AST_COMM_TWO: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
      (tick && (outTwoSourceSelect == SRC_COMM_MODBUS || outTwoSourceSelect == SRC_COMM_CARD))
        |=> digitalOutputTwo == $past(commOutputValue[4]))
    else $error("Output two not following register bit 4");

  AST_COMM_WRITE: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
      (regWrEn && regAddr == ADDR_COMM_OUTPUT_VALUE) |=>
        commOutputValue == ($past(regWrData) & COMM_OUTPUT_VALUE_MASK))
    else $error("Communication register did not take write");

  AST_FIRE: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
      (tick && relaySourceSelect == SRC_FIRE_MODE && $past(fireModePin, 2)) |=> relayOutput)
    else $error("Fire mode indication missing");

  AST_FIRE_ONE: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
      (tick && outOneSourceSelect == SRC_FIRE_MODE && !$past(fireModePin, 2)) |=> !digitalOutputOne)
    else $error("Fire mode indication without input");

  AST_HOLD: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
      !tick |=> $stable(terminalState))
    else $error("Terminal changed between control cycles");

  AST_TICK_GAP: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
      tick |=> !tick [*8] ##1 !tick ##1 tick)
    else $error("Control cycle period wrong");

  // Read port answers one clock after the strobe
  AST_RD_VALID: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
      regRdEn |=> regRdValid)
    else $error("Read not answered");

  AST_RD_IDLE: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
      !regRdEn |=> (!regRdValid && regRdData == 16'h0000))
    else $error("Read data not cleared when idle");

  AST_RD_COMM: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
      (regRdEn && regAddr == ADDR_COMM_OUTPUT_VALUE) |=> regRdData == $past(commOutputValue))
    else $error("Communication register read wrong");

  AST_STATUS: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
      (regRdEn && regAddr == ADDR_OUTPUT_STATUS) |=> regRdData == {13'h0000, $past(terminalState)})
    else $error("Status read wrong");

  // Main scenarios
  COV_COMM_RELAY: cover property (
    @(posedge sys_clk) disable iff (!arst_n)
      tick && relaySourceSelect == SRC_COMM_CARD ##1 relayOutput);

  COV_DEB: cover property (
    @(posedge sys_clk) disable iff (!arst_n)
      tick && outOneSourceSelect == SRC_MASTER_DEB && decelEnergyBackup ##1 digitalOutputOne);

  COV_VALVE: cover property (
    @(posedge sys_clk) disable iff (!arst_n)
      tick && outTwoSourceSelect == SRC_VALVE_SWITCH ##1 digitalOutputTwo);

  COV_STATUS_READ: cover property (
    @(posedge sys_clk) disable iff (!arst_n)
      regRdEn && regAddr == ADDR_OUTPUT_STATUS ##1 regRdValid && regRdData != 16'h0000);

  COV_FIRE: cover property (
    @(posedge sys_clk) disable iff (!arst_n)
      tick && relaySourceSelect == SRC_FIRE_MODE ##1 relayOutput);

endmodule // mos_selector
`default_nettype wire

// >>> tb/mos_load_model.sv
/*
  Far-side model: output contactor on digital output one and a slave drive
  that listens for the deceleration backup signal on either digital output.
  Assumes the terminals are registered on sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module mos_load_model (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic digitalOutputOne,
  input wire logic digitalOutputTwo,
  output logic contactorClosed,
  output logic slaveBackupActive
);
  // Coil follows the valve terminal
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      contactorClosed <= 1'h0;
    end else begin
      contactorClosed <= digitalOutputOne;
    end
  end

  // Slave stays in backup until its own stop, modelled as reset
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      slaveBackupActive <= 1'h0;
    end else if (digitalOutputOne | digitalOutputTwo) begin
      slaveBackupActive <= 1'h1;
    end
  end
endmodule // mos_load_model
`default_nettype wire

// >>> tb/tb.sv
/*
  Self-checking bench for the output selector: register tasks and terminal scenarios.
  Assumes the 10-clock control cycle and the constants of mos_pkg.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import mos_pkg::*;
  logic sys_clk = 1'h0;
  logic arst_n = 1'h0;
  logic [7:0] relaySel = 8'h00, oneSel = 8'h00, twoSel = 8'h00;
  logic [10:0] c = 11'h000;
  logic [15:0] speed = 16'h0064, thr = 16'h00C8, addr = 16'h0000, wdata = 16'h0000, rdData;
  logic wrEn = 1'h0, rdEn = 1'h0, rdValid, relayOut, outOne, outTwo, valveOn, slaveDeb;
  logic [2:0] prevOut = 3'h0;
  int badCount = 0, totalChecks = 0, cyc = 0, lastChange = 0;

  mos_selector DUT (.sys_clk(sys_clk), .arst_n(arst_n), .relaySourceSelect(relaySel),
    .outOneSourceSelect(oneSel), .outTwoSourceSelect(twoSel), .driveRunning(c[4]),
    .actualFreqZero(c[5]), .speedReached(c[6]), .errorSelectFlag(c[3:0]),
    .pulseInputTerminalMode(c[7]), .motorSpeed(speed), .speedThreshold(thr),
    .decelEnergyBackup(c[8]), .driveEnablePin(c[9]), .fireModePin(c[10]), .regWrEn(wrEn),
    .regRdEn(rdEn), .regAddr(addr), .regWrData(wdata), .regRdData(rdData),
    .regRdValid(rdValid), .relayOutput(relayOut), .digitalOutputOne(outOne),
    .digitalOutputTwo(outTwo));

  mos_load_model partner (.sys_clk(sys_clk), .arst_n(arst_n), .digitalOutputOne(outOne),
    .digitalOutputTwo(outTwo), .contactorClosed(valveOn), .slaveBackupActive(slaveDeb));

  initial begin
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      badCount++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    if (badCount == 0 && totalChecks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic wrReg(input logic [15:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    wrEn <= 1'h1;
    addr <= a;
    wdata <= d;
    @(posedge sys_clk);
    wrEn <= 1'h0;
  endtask

  task automatic rdCheck(input logic [15:0] a, input logic [15:0] exp);
    @(posedge sys_clk);
    rdEn <= 1'h1;
    addr <= a;
    @(posedge sys_clk);
    rdEn <= 1'h0;
    #1;
    check("read valid", {15'h0000, rdValid}, 16'h0001);
    check("read data", rdData, exp);
  endtask

  // Pins pass a 2-flop sync, so wait past the 13-clock worst case
  task automatic term(input logic [7:0] r, input logic [7:0] o, input logic [7:0] t,
                      input logic [10:0] cond, input logic [2:0] exp);
    @(posedge sys_clk);
    relaySel <= r;
    oneSel <= o;
    twoSel <= t;
    c <= cond;
    repeat (14) @(posedge sys_clk);
    #1;
    check("terminals two one relay", {13'h0000, outTwo, outOne, relayOut}, {13'h0000, exp});
  endtask

  // Terminals may only move on control-cycle boundaries
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    // Reset restarts the control cycle, so spacing is counted afresh
    if (!arst_n) begin
      lastChange <= 0;
      prevOut <= 3'h0;
    end else if ({outTwo, outOne, relayOut} !== prevOut) begin
      if (lastChange != 0) check("update spacing", 16'((cyc - lastChange) % 10), 16'h0000);
      lastChange <= cyc;
      prevOut <= {outTwo, outOne, relayOut};
    end
  end

  initial begin
    repeat (3000) @(posedge sys_clk);
    badCount++;
    results();
  end

  initial begin
    repeat (12) @(posedge sys_clk);
    arst_n <= 1'h1;
    term(SRC_ZERO_RUN, SRC_ZERO_OR_STOP, SRC_SPEED_REACHED, 11'h030, 3'h3);
    term(SRC_ZERO_RUN, SRC_ZERO_OR_STOP, SRC_SPEED_REACHED, 11'h020, 3'h6);
    term(SRC_ZERO_RUN, SRC_ZERO_OR_STOP, SRC_SPEED_REACHED, 11'h010, 3'h0);
    term(SRC_ZERO_RUN, SRC_ZERO_OR_STOP, SRC_SPEED_REACHED, 11'h050, 3'h4);
    term(SRC_ZERO_RUN, SRC_ZERO_OR_STOP, SRC_SPEED_REACHED, 11'h000, 3'h6);
    term(SRC_SPEED_REACHED, SRC_ZERO_OR_STOP, SRC_ZERO_RUN, 11'h000, 3'h3);
    for (int i = 0; i < 4; i++) begin
      term(8'(SRC_ERROR_ONE + i), 8'(SRC_ERROR_ONE + i), 8'(SRC_ERROR_ONE + i), 11'(1 << i), 3'h7);
      term(8'(SRC_ERROR_ONE + i), 8'(SRC_ERROR_ONE + i), 8'(SRC_ERROR_ONE + i), 11'(15 ^ (1 << i)), 3'h0);
    end
    term(SRC_PULSE_SPEED_LOW, SRC_PULSE_SPEED_LOW, SRC_PULSE_SPEED_LOW, 11'h080, 3'h7);
    term(SRC_PULSE_SPEED_LOW, SRC_PULSE_SPEED_LOW, SRC_PULSE_SPEED_LOW, 11'h000, 3'h0);
    @(posedge sys_clk);
    speed <= 16'h00C8;
    term(SRC_PULSE_SPEED_LOW, SRC_PULSE_SPEED_LOW, SRC_PULSE_SPEED_LOW, 11'h080, 3'h0);
    term(SRC_VALVE_SWITCH, SRC_VALVE_SWITCH, SRC_VALVE_SWITCH, 11'h210, 3'h7);
    check("contactor", {15'h0000, valveOn}, 16'h0001);
    term(SRC_VALVE_SWITCH, SRC_VALVE_SWITCH, SRC_VALVE_SWITCH, 11'h200, 3'h0);
    term(SRC_VALVE_SWITCH, SRC_VALVE_SWITCH, SRC_VALVE_SWITCH, 11'h010, 3'h0);
    // Mid-run reset clears the latched slave so the backup test is not hollow
    @(posedge sys_clk);
    arst_n <= 1'h0;
    repeat (2) @(posedge sys_clk);
    #1;
    check("terminals in reset", {13'h0000, outTwo, outOne, relayOut}, 16'h0000);
    check("slave after reset", {15'h0000, slaveDeb}, 16'h0000);
    @(posedge sys_clk);
    arst_n <= 1'h1;
    term(SRC_MASTER_DEB, SRC_MASTER_DEB, SRC_MASTER_DEB, 11'h000, 3'h0);
    check("slave idle", {15'h0000, slaveDeb}, 16'h0000);
    term(SRC_MASTER_DEB, SRC_MASTER_DEB, SRC_MASTER_DEB, 11'h100, 3'h6);
    check("slave backup", {15'h0000, slaveDeb}, 16'h0001);
    term(SRC_FIRE_MODE, SRC_FIRE_MODE, SRC_FIRE_MODE, 11'h400, 3'h7);
    term(SRC_FIRE_MODE, SRC_FIRE_MODE, SRC_FIRE_MODE, 11'h000, 3'h0);
    term(8'h27, 8'h29, 8'h2F, 11'h7FF, 3'h0);
    rdCheck(ADDR_COMM_OUTPUT_VALUE, 16'h0000);
    wrReg(ADDR_COMM_OUTPUT_VALUE, 16'hFFFF);
    rdCheck(ADDR_COMM_OUTPUT_VALUE, 16'h0019);
    term(SRC_COMM_MODBUS, SRC_COMM_CARD, SRC_COMM_MODBUS, 11'h000, 3'h7);
    wrReg(ADDR_COMM_OUTPUT_VALUE, 16'h0008);
    term(SRC_COMM_CARD, SRC_COMM_MODBUS, SRC_COMM_CARD, 11'h000, 3'h2);
    wrReg(ADDR_COMM_OUTPUT_VALUE, 16'h0011);
    term(SRC_COMM_CARD, SRC_COMM_MODBUS, SRC_COMM_CARD, 11'h000, 3'h5);
    rdCheck(ADDR_OUTPUT_STATUS, 16'h0005);
    rdCheck(16'h1234, 16'h0000);
    results();
  end
endmodule // tb
`default_nettype wire
